// ---- dv/dis_mem_model.sv ----
`timescale 1ns/1ps
module dis_mem_model #(
    parameter int DLY = 2
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic slow,
    input wire logic st_done_valid,
    output logic st_retire
);
    int pend;
    int wait_c;
    // retire queued stores one at a time, prompt or slow
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pend <= 0;
            wait_c <= 0;
            st_retire <= 1'b0;
        end
        else
        begin
            st_retire <= 1'b0;
            wait_c <= (pend > 0) ? wait_c + 1 : 0;
            pend <= pend + int'(st_done_valid);
            if (pend > 0 && wait_c >= (slow ? 8 : DLY))
            begin
                st_retire <= 1'b1;
                wait_c <= 0;
                pend <= pend - 1 + int'(st_done_valid);
            end
        end
    end
endmodule : dis_mem_model

// ---- dv/dis_sched_bench.sv ----
`timescale 1ns/1ps
module dis_sched_bench
    import dis_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic dec_valid = 1'b0;
    logic slow = 1'b1;
    logic [2:0] dec_cls = 3'h0;
    logic [REG_W-1:0] dec_dst = 4'h0, dec_dst_hi = 4'h0, dec_src_a = 4'h0, dec_src_b = 4'h0;
    logic [ADDR_W-1:0] dec_addr = 8'h00;
    logic [15:0] rnd = 16'h0020;
    logic st_retire, dec_ready, x_exec_valid, y_exec_valid, ld_done_valid, ld_fwd, st_done_valid, bump_x, bump_y;
    logic [REG_W-1:0] x_exec_dst, y_exec_dst, ld_done_dst;
    logic [ADDR_W-1:0] st_done_addr;
    logic [ADDR_W-1:0] sa = 8'h00;
    logic fw[NREG];
    logic sh[NREG];
    int n_mismatch = 0, check_count = 0, cyc = 0, tk, t, bumps = 0;
    int xc[NREG], yc[NREG], lc[NREG], xn[NREG], yn[NREG];

    dis_sched dut (.clk(clk), .srst(srst), .dec_valid(dec_valid), .dec_cls(dec_cls), .dec_dst(dec_dst),
        .dec_dst_hi(dec_dst_hi), .dec_src_a(dec_src_a), .dec_src_b(dec_src_b), .dec_addr(dec_addr),
        .st_retire(st_retire), .dec_ready(dec_ready), .x_exec_valid(x_exec_valid), .x_exec_dst(x_exec_dst),
        .y_exec_valid(y_exec_valid), .y_exec_dst(y_exec_dst), .ld_done_valid(ld_done_valid),
        .ld_done_dst(ld_done_dst), .ld_fwd(ld_fwd), .st_done_valid(st_done_valid), .st_done_addr(st_done_addr),
        .bump_x(bump_x), .bump_y(bump_y));
    dis_mem_model u_mem (.clk(clk), .srst(srst), .slow(slow), .st_done_valid(st_done_valid), .st_retire(st_retire));

    // ------------------------------------------------------------
    // clock, timeout, event log
    // ------------------------------------------------------------
    initial forever #50 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc > 4000)
        begin
            n_mismatch++;
            conclude();
        end
    end
    always @(negedge clk)
    begin
        if (x_exec_valid === 1'b1) begin xc[x_exec_dst] = cyc; xn[x_exec_dst]++; end
        if (y_exec_valid === 1'b1) begin yc[y_exec_dst] = cyc; yn[y_exec_dst]++; end
        if (ld_done_valid === 1'b1) begin lc[ld_done_dst] = cyc; fw[ld_done_dst] = ld_fwd; end
        if (bump_x === 1'b1 || bump_y === 1'b1) bumps++;
        if (st_done_valid === 1'b1) sa = st_done_addr;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic int alu_at(input int tt);
        return tt + 3;
    endfunction : alu_at
    function automatic int when(input int d);
        return (yn[d] > 0) ? yc[d] : xc[d];
    endfunction : when
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic offer(input logic [2:0] c, input logic [3:0] d, h, a, b, input logic [7:0] ad);
        int k;
        k = 0;
        @(negedge clk);
        {dec_valid, dec_cls, dec_dst, dec_dst_hi, dec_src_a, dec_src_b, dec_addr} = {1'b1, c, d, h, a, b, ad};
        while (dec_ready !== 1'b1 && k < 60)
        begin
            @(negedge clk);
            k++;
        end
        @(posedge clk);
        tk = cyc + 1;
    endtask : offer
    task automatic settle();
        @(negedge clk);
        dec_valid = 1'b0;
        repeat (20) @(posedge clk);
    endtask : settle
    task automatic clr();
        foreach (xn[i])
        begin
            xn[i] = 0;
            yn[i] = 0;
        end
    endtask : clr
    task automatic conclude();
        $display("mismatches %0d, checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        check(dec_ready, 1'b1);
        clr();
        offer(CLS_ALU, 1, 0, 0, 0, 0);
        t = tk;
        settle();
        check(yc[1], alu_at(t));
        offer(CLS_ALU, 2, 0, 0, 0, 0);
        offer(CLS_ALU, 3, 0, 2, 0, 0);
        settle();
        check(when(3), when(2) + 1);
        offer(CLS_LIMM, 4, 0, 0, 0, 0);
        offer(CLS_ALU, 5, 0, 4, 0, 0);
        t = tk;
        settle();
        check(when(5), alu_at(t));
        check(xn[4] + yn[4], 0);
        offer(CLS_MUL, 6, 7, 1, 1, 0);
        offer(CLS_SHIFT, 8, 0, 0, 0, 0);
        settle();
        check(yn[6] + yn[7] + yn[8], 0);
        check(xc[7], xc[6] + 1);
        check(xc[8] > xc[7], 1'b1);
        t = bumps;
        offer(CLS_LOAD, 10, 0, 0, 0, 8'h10);
        tk = tk;
        offer(CLS_ALU, 11, 0, 10, 0, 0);
        settle();
        check(bumps > t, 1'b1);
        check(when(11) > lc[10], 1'b1);
        offer(CLS_LOAD, 12, 0, 0, 0, 8'h20);
        t = tk;
        offer(CLS_LOAD, 13, 0, 0, 0, 8'h21);
        settle();
        check(lc[12], t + 4);
        check(lc[13], lc[12] + 1);
        offer(CLS_ALU, 14, 0, 0, 0, 0);
        offer(CLS_LOAD, 15, 0, 14, 0, 8'h22);
        t = tk;
        settle();
        check(lc[15], t + 4);
        offer(CLS_STORE, 0, 0, 0, 0, 8'h30);
        offer(CLS_LOAD, 1, 0, 0, 0, 8'h30);
        offer(CLS_LOAD, 2, 0, 0, 0, 8'h31);
        settle();
        check(fw[1], 1'b1);
        check(fw[2], 1'b0);
        check(sa, 8'h30);
        slow = 1'b0;
        repeat (4)
        begin
            clr();
            for (int i = 1; i < 9; i++)
            begin
                rnd = lfsr(rnd);
                sh[i] = rnd[0];
                offer(rnd[0] ? CLS_SHIFT : CLS_ALU, 4'(i), 0, rnd[4:1], rnd[8:5], 0);
            end
            settle();
            for (int i = 1; i < 9; i++)
            begin
                check(xn[i] + yn[i], 1);
                if (sh[i]) check(yn[i], 0);
            end
        end
        @(negedge clk);
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        check(dec_ready, 1'b1);
        conclude();
    end
endmodule : dis_sched_bench

bind dis_sched dis_sched_monitor u_mon (.clk(clk), .srst(srst), .dec_ready(dec_ready), .x_exec_valid(x_exec_valid),
    .y_exec_valid(y_exec_valid), .ld_done_valid(ld_done_valid), .ld_fwd(ld_fwd), .st_done_valid(st_done_valid),
    .bump_x(bump_x), .bump_y(bump_y));

// ---- dv/dis_sched_monitor.sv ----
`timescale 1ns/1ps
module dis_sched_monitor (
    input wire logic clk,
    input wire logic srst,
    input wire logic dec_ready,
    input wire logic x_exec_valid,
    input wire logic y_exec_valid,
    input wire logic ld_done_valid,
    input wire logic ld_fwd,
    input wire logic st_done_valid,
    input wire logic bump_x,
    input wire logic bump_y
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence rel_s;
        $fell(srst);
    endsequence
    a_reset_quiet: assert property (disable iff (1'b0) srst |=> dec_ready && !x_exec_valid && !ld_done_valid)
        else $error("outputs not quiet in reset");
    a_x_first_gap: assert property (rel_s |-> !x_exec_valid [*3])
        else $error("x exec too early after reset");
    a_y_first_gap: assert property (rel_s |-> !y_exec_valid [*3])
        else $error("y exec too early after reset");
    a_load_first_gap: assert property (rel_s |-> !ld_done_valid [*4])
        else $error("load done too early after reset");
    a_store_first_gap: assert property (rel_s |-> !st_done_valid [*4])
        else $error("store done too early after reset");
    a_bump_first_gap: assert property (rel_s |-> !bump_x && !bump_y [*2])
        else $error("bump too early after reset");
    a_fwd_with_load: assert property (ld_fwd |-> ld_done_valid)
        else $error("forward flag without load");
    a_ready_returns: assert property (!dec_ready |-> ##[1:60] dec_ready)
        else $error("decode port stuck");
endmodule : dis_sched_monitor

// ---- hdl/dis_pipe.sv ----
`timescale 1ns/1ps
module dis_pipe #(
    parameter int TAG_W = 4
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic in_valid,
    input wire logic [TAG_W-1:0] in_tag,
    input wire logic hold,
    output logic o_valid,
    output logic [TAG_W-1:0] o_tag,
    output logic e1_valid,
    output logic [TAG_W-1:0] e1_tag,
    output logic e2_valid,
    output logic [TAG_W-1:0] e2_tag
);

    typedef struct packed {
        logic ov;
        logic [TAG_W-1:0] ot;
        logic e1v;
        logic [TAG_W-1:0] e1t;
        logic e2v;
        logic [TAG_W-1:0] e2t;
    } dis_pipe_st_t;

    dis_pipe_st_t s_q;
    dis_pipe_st_t s_d;

    // ------------------------------------------------------------
    // operand fetch, exec 1, exec 2
    // ------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        if (!hold)
        begin
            s_d.ov = in_valid;
            s_d.ot = in_tag;
        end
        s_d.e1v = s_q.ov && !hold;
        s_d.e1t = s_q.ot;
        s_d.e2v = s_q.e1v;
        s_d.e2t = s_q.e1t;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign o_valid = s_q.ov;
    assign o_tag = s_q.ot;
    assign e1_valid = s_q.e1v;
    assign e1_tag = s_q.e1t;
    assign e2_valid = s_q.e2v;
    assign e2_tag = s_q.e2t;

endmodule : dis_pipe

// ---- hdl/dis_sched.sv ----
// Notes on behaviour
// - multiply spends two decode cycles
// - multiply only in X, not pipelined
// - multiply is three serial uops, lo then hi
// - load immediate uses no unit, instant result
// - shifts X only, wait behind multiply
// - long operand wait evicts, reissue next cycle
// - next alu, shift or multiply op waits until evicted ops are reissued; loads, stores and limm do not wait
// - Y contention sends issue to X, if X is free
// - load address waits for ready, no bypass
// - loads run back to back, one per clock
// - load operand fetch stalls on unready address
// - reissue lines operand fetch with load result
// - alu ops go to X or Y, whichever free
// - results bypass to alu, shift and multiply dependents with no latency; load and store operands wait for ready
// - store queue forwards to same-address loads
// - stages issue, fetch, exec1, exec2 in order
// - one load starts per cycle, others stall
`timescale 1ns/1ps
module dis_sched
    import dis_pkg::*;
#(
    parameter int SQ_DEPTH = 4
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic dec_valid,
    input wire logic [2:0] dec_cls,
    input wire logic [REG_W-1:0] dec_dst,
    input wire logic [REG_W-1:0] dec_dst_hi,
    input wire logic [REG_W-1:0] dec_src_a,
    input wire logic [REG_W-1:0] dec_src_b,
    input wire logic [ADDR_W-1:0] dec_addr,
    input wire logic st_retire,
    output logic dec_ready,
    output logic x_exec_valid,
    output logic [REG_W-1:0] x_exec_dst,
    output logic y_exec_valid,
    output logic [REG_W-1:0] y_exec_dst,
    output logic ld_done_valid,
    output logic [REG_W-1:0] ld_done_dst,
    output logic ld_fwd,
    output logic st_done_valid,
    output logic [ADDR_W-1:0] st_done_addr,
    output logic bump_x,
    output logic bump_y
);

    localparam int SQ_AW = $clog2(SQ_DEPTH);
    localparam int MT_W = ADDR_W + 2 * REG_W;

    typedef struct packed {
        dis_op_t [1:0] q;
        logic [1:0] qcnt;
        logic rdy;
        dis_op_t [1:0] ri;
        dis_op_t [1:0] iu;
        dis_op_t il;
        dis_op_t is;
        logic [NREG-1:0][1:0] pend;
        dis_mph_t mph;
        logic [1:0] mstep;
        logic [1:0] mbusy;
        logic [SQ_DEPTH-1:0] sqv;
        logic [SQ_DEPTH-1:0][ADDR_W-1:0] sqa;
        logic [SQ_AW-1:0] wp;
        logic [SQ_AW-1:0] rp;
        logic fwd;
        logic [1:0] bump;
    } dis_st_t;

    dis_st_t s_q;
    dis_st_t s_d;

    logic [1:0] u_in_v;
    logic [1:0][REG_W-1:0] u_in_tag;
    logic [1:0] u_o_v;
    logic [1:0][REG_W-1:0] u_o_tag;
    logic [1:0] u_e1_v;
    logic [1:0][REG_W-1:0] u_e1_tag;
    logic l_in_v, l_hold, l_o_v, l_e1_v, l_e2_v;
    logic [MT_W-1:0] l_in_tag, l_o_tag, l_e1_tag, l_e2_tag;
    logic s_in_v, s_hold, s_o_v, s_e2_v;
    logic [MT_W-1:0] s_in_tag, s_o_tag, s_e2_tag;
    dis_op_t [1:0] bq;
    dis_op_t h;
    dis_op_t hop;
    logic [1:0] claim;
    logic [1:0] pk;
    logic x_free, r_empty, pop, acc;
    logic [1:0] cnt_pop;

    // pick a register unit: {found, unit}
    function automatic logic [1:0] dis_pick(input dis_cls_t c, input logic pref,
                                            input logic [1:0] cl, input logic xf);
        logic ok_x;
        logic ok_y;
        ok_x = xf && !cl[UNIT_X];
        ok_y = !cl[UNIT_Y];
        if (c == CLS_SHIFT)
            return {ok_x, UNIT_X};
        if (pref == UNIT_Y)
            return ok_y ? {1'b1, UNIT_Y} : {ok_x, UNIT_X};
        return ok_x ? {1'b1, UNIT_X} : {ok_y, UNIT_Y};
    endfunction : dis_pick

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        s_d.bump = '0;
        s_d.fwd = 1'b0;
        claim = '0;
        bq = '0;
        pk = '0;
        pop = 1'b0;
        acc = 1'b0;
        h = s_q.q[0];
        hop = s_q.q[0];
        x_free = (s_q.mbusy == 2'h0);
        for (int r = 0; r < NREG; r++)
            if (s_q.pend[r] == PEND_BYPASS)
                s_d.pend[r] = PEND_READY;
        if (s_q.mbusy != 2'h0)
            s_d.mbusy = s_q.mbusy - 2'h1;

        // register unit issue stage: advance or evict
        for (int u = 0; u < 2; u++)
        begin
            s_d.iu[u] = '0;
            u_in_v[u] = 1'b0;
            u_in_tag[u] = s_q.iu[u].dst;
            if (s_q.iu[u].v)
            begin
                if (s_q.iu[u].cls != CLS_MULU &&
                    ((s_q.iu[u].src_a != s_q.iu[u].dst && s_q.pend[s_q.iu[u].src_a] == PEND_WAIT) ||
                     (s_q.iu[u].src_b != s_q.iu[u].dst && s_q.pend[s_q.iu[u].src_b] == PEND_WAIT)))
                begin
                    bq[u] = s_q.iu[u];
                    s_d.bump[u] = 1'b1;
                end
                else
                begin
                    u_in_v[u] = 1'b1;
                    if (s_q.iu[u].dst != NO_REG)
                        s_d.pend[s_q.iu[u].dst] = PEND_BYPASS;
                end
            end
        end

        // reissue of evicted ops, ahead of new ones
        for (int k = 0; k < 2; k++)
        begin
            if (s_q.ri[k].v)
            begin
                pk = dis_pick(s_q.ri[k].cls, (k == 1) ? UNIT_Y : UNIT_X, claim, x_free);
                if (pk[1])
                begin
                    s_d.iu[pk[0]] = s_q.ri[k];
                    claim[pk[0]] = 1'b1;
                    s_d.ri[k].v = 1'b0;
                end
            end
        end
        for (int u = 0; u < 2; u++)
        begin
            if (bq[u].v)
            begin
                if (!s_d.ri[0].v)
                    s_d.ri[0] = bq[u];
                else
                    s_d.ri[1] = bq[u];
            end
        end
        r_empty = !s_d.ri[0].v && !s_d.ri[1].v;

        // load unit
        // own destination as address reads the old value
        l_hold = l_o_v && l_o_tag[2*REG_W-1:REG_W] != l_o_tag[REG_W-1:0] &&
                 s_q.pend[l_o_tag[2*REG_W-1:REG_W]] != PEND_READY;
        l_in_v = s_q.il.v && !l_hold;
        l_in_tag = {s_q.il.addr, s_q.il.src_a, s_q.il.dst};
        if (l_in_v)
            s_d.il.v = 1'b0;
        if (l_o_v && !l_hold && l_o_tag[REG_W-1:0] != NO_REG)
            s_d.pend[l_o_tag[REG_W-1:0]] = PEND_BYPASS;
        for (int e = 0; e < SQ_DEPTH; e++)
            if (l_e1_v && s_q.sqv[e] && s_q.sqa[e] == l_e1_tag[MT_W-1 -: ADDR_W])
                s_d.fwd = 1'b1;

        // store unit and store queue
        s_hold = s_o_v && (s_q.pend[s_o_tag[2*REG_W-1:REG_W]] != PEND_READY ||
                 s_q.pend[s_o_tag[REG_W-1:0]] != PEND_READY || s_q.sqv[s_q.wp]);
        s_in_v = s_q.is.v && !s_hold;
        s_in_tag = {s_q.is.addr, s_q.is.src_a, s_q.is.src_b};
        if (s_in_v)
            s_d.is.v = 1'b0;
        if (s_o_v && !s_hold)
        begin
            s_d.sqv[s_q.wp] = 1'b1;
            s_d.sqa[s_q.wp] = s_o_tag[MT_W-1 -: ADDR_W];
            s_d.wp = s_q.wp + 1'b1;
        end
        if (st_retire && s_q.sqv[s_q.rp])
        begin
            s_d.sqv[s_q.rp] = 1'b0;
            s_d.rp = s_q.rp + 1'b1;
        end

        // head of the decode queue
        if (s_q.qcnt != 2'h0)
        begin
            case (h.cls)
                CLS_LIMM:
                begin
                    if (h.dst != NO_REG)
                        s_d.pend[h.dst] = PEND_READY;
                    pop = 1'b1;
                end
                CLS_LOAD:
                begin
                    if (!s_q.il.v || l_in_v)
                    begin
                        s_d.il = h;
                        if (h.dst != NO_REG)
                            s_d.pend[h.dst] = PEND_WAIT;
                        pop = 1'b1;
                    end
                end
                CLS_STORE:
                begin
                    if (!s_q.is.v || s_in_v)
                    begin
                        s_d.is = h;
                        pop = 1'b1;
                    end
                end
                CLS_MUL:
                begin
                    case (s_q.mph)
                        MP_IDLE:
                        begin
                            s_d.mph = MP_DEC;
                        end
                        MP_DEC:
                        begin
                            s_d.mph = MP_UOP;
                            s_d.mstep = 2'h0;
                        end
                        MP_UOP:
                        begin
                            if (!claim[UNIT_X] && (s_q.mstep != 2'h0 || (r_empty &&
                                s_q.pend[h.src_a] != PEND_WAIT && s_q.pend[h.src_b] != PEND_WAIT)))
                            begin
                                hop.cls = CLS_MULU;
                                hop.dst = (s_q.mstep == MUL_LAST) ? h.dst_hi :
                                          (s_q.mstep == MUL_LO_STEP) ? h.dst : NO_REG;
                                s_d.iu[UNIT_X] = hop;
                                claim[UNIT_X] = 1'b1;
                                if (s_q.mstep == 2'h0)
                                begin
                                    s_d.mbusy = MUL_OCC;
                                    if (h.dst != NO_REG)
                                        s_d.pend[h.dst] = PEND_WAIT;
                                    if (h.dst_hi != NO_REG)
                                        s_d.pend[h.dst_hi] = PEND_WAIT;
                                end
                                s_d.mstep = s_q.mstep + 2'h1;
                                if (s_q.mstep == MUL_LAST)
                                begin
                                    pop = 1'b1;
                                    s_d.mph = MP_IDLE;
                                end
                            end
                        end
                        default:
                            s_d.mph = MP_IDLE;
                    endcase
                end
                default:
                begin
                    if (r_empty)
                    begin
                        pk = dis_pick(h.cls, UNIT_Y, claim, x_free);
                        if (pk[1])
                        begin
                            s_d.iu[pk[0]] = h;
                            if (h.dst != NO_REG)
                                s_d.pend[h.dst] = PEND_WAIT;
                            pop = 1'b1;
                        end
                    end
                end
            endcase
        end

        // decode queue pop and accept
        if (pop)
        begin
            s_d.q[0] = s_q.q[1];
            s_d.q[1] = '0;
        end
        cnt_pop = s_q.qcnt - {1'b0, pop};
        if (dec_valid && s_q.rdy)
        begin
            acc = 1'b1;
            s_d.q[cnt_pop[0]] = {1'b1, dis_cls_t'(dec_cls), dec_dst, dec_dst_hi, dec_src_a, dec_src_b, dec_addr};
        end
        s_d.qcnt = cnt_pop + {1'b0, acc};
        s_d.rdy = (s_d.qcnt < QDEPTH);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s_q <= '0;
            s_q.rdy <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    // ------------------------------------------------------------
    // unit pipelines
    // ------------------------------------------------------------
    for (genvar u = 0; u < 2; u++)
    begin : g_reg_unit
        dis_pipe #(.TAG_W(REG_W)) u_pipe (
            .clk(clk), .srst(srst), .in_valid(u_in_v[u]), .in_tag(u_in_tag[u]), .hold(1'b0),
            .o_valid(u_o_v[u]), .o_tag(u_o_tag[u]), .e1_valid(u_e1_v[u]), .e1_tag(u_e1_tag[u]),
            .e2_valid(), .e2_tag()
        );
    end

    dis_pipe #(.TAG_W(MT_W)) u_load (
        .clk(clk), .srst(srst), .in_valid(l_in_v), .in_tag(l_in_tag), .hold(l_hold),
        .o_valid(l_o_v), .o_tag(l_o_tag), .e1_valid(l_e1_v), .e1_tag(l_e1_tag),
        .e2_valid(l_e2_v), .e2_tag(l_e2_tag)
    );

    dis_pipe #(.TAG_W(MT_W)) u_store (
        .clk(clk), .srst(srst), .in_valid(s_in_v), .in_tag(s_in_tag), .hold(s_hold),
        .o_valid(s_o_v), .o_tag(s_o_tag), .e1_valid(), .e1_tag(),
        .e2_valid(s_e2_v), .e2_tag(s_e2_tag)
    );

    assign dec_ready = s_q.rdy;
    assign x_exec_valid = u_e1_v[UNIT_X];
    assign x_exec_dst = u_e1_tag[UNIT_X];
    assign y_exec_valid = u_e1_v[UNIT_Y];
    assign y_exec_dst = u_e1_tag[UNIT_Y];
    assign ld_done_valid = l_e2_v;
    assign ld_done_dst = l_e2_tag[REG_W-1:0];
    assign ld_fwd = s_q.fwd;
    assign st_done_valid = s_e2_v;
    assign st_done_addr = s_e2_tag[MT_W-1 -: ADDR_W];
    assign bump_x = s_q.bump[UNIT_X];
    assign bump_y = s_q.bump[UNIT_Y];

endmodule : dis_sched

// ---- include/dis_pkg.sv ----
package dis_pkg;

    // ------------------------------------------------------------
    // widths and register tags
    // ------------------------------------------------------------
    localparam int REG_W = 4;
    localparam int NREG = 16;
    localparam int ADDR_W = 8;
    localparam logic [REG_W-1:0] NO_REG = 4'h0;

    // ------------------------------------------------------------
    // operand availability codes
    // ------------------------------------------------------------
    localparam logic [1:0] PEND_READY = 2'h0;
    localparam logic [1:0] PEND_BYPASS = 2'h1;
    localparam logic [1:0] PEND_WAIT = 2'h2;

    // ------------------------------------------------------------
    // units, multiply timing and decode queue depth
    // ------------------------------------------------------------
    localparam logic UNIT_X = 1'b0;
    localparam logic UNIT_Y = 1'b1;
    localparam logic [1:0] MUL_OCC = 2'h3;
    localparam logic [1:0] MUL_LAST = 2'h2;
    localparam logic [1:0] MUL_LO_STEP = 2'h1;
    localparam logic [1:0] QDEPTH = 2'h2;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CLS_ALU = 3'b000,
        CLS_SHIFT = 3'b001,
        CLS_MUL = 3'b010,
        CLS_LIMM = 3'b011,
        CLS_LOAD = 3'b100,
        CLS_STORE = 3'b101,
        CLS_MULU = 3'b110
    } dis_cls_t;

    typedef enum logic [1:0] {
        MP_IDLE = 2'b00,
        MP_DEC = 2'b01,
        MP_UOP = 2'b10
    } dis_mph_t;

    typedef struct packed {
        logic v;
        dis_cls_t cls;
        logic [REG_W-1:0] dst;
        logic [REG_W-1:0] dst_hi;
        logic [REG_W-1:0] src_a;
        logic [REG_W-1:0] src_b;
        logic [ADDR_W-1:0] addr;
    } dis_op_t;

endpackage : dis_pkg
